// ==== design/lpc_defs.vh ====
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// ----------------------------------------------------------------
// Frame identifiers and command codes
// ----------------------------------------------------------------
`define LPC_RESERVED_ID   8'h3c
`define LPC_APP_CMD       8'h80
`define LPC_CMD_OTP       8'h90
`define LPC_CMD_MOVE      8'h8b
`define LPC_OTP_ADDR_TAG  5'h1e
`define LPC_GP_ID_TAG     2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LPC_BROAD_BIT     7
`define LPC_OTP_TAG_LSB   3

// ----------------------------------------------------------------
// Least data byte counts per frame form, store byte limit and last read index
// ----------------------------------------------------------------
`define LPC_LEN_DYN       4'h2
`define LPC_LEN_GP        4'h4
`define LPC_LEN_RSV       4'h8
`define LPC_LEN_MAX       4'h8
`define LPC_READ_LAST     3'h4

`endif

// ==== design/lpc_frame_mem.v ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Frame byte store, registered read
// ----------------------------------------------------------------
module lpc_frame_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,  // System clock
  input  wire             ce,        // Clock enable
  input  wire             wr_en,     // Write strobe
  input  wire [AW-1:0]    wr_addr,   // Write index
  input  wire [WIDTH-1:0] wr_data,   // Write byte
  input  wire             rd_en,     // Read strobe
  input  wire [AW-1:0]    rd_addr,   // Read index
  output reg  [WIDTH-1:0] rd_data    // Read byte, one cycle late
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // No reset on the array; readers only look at bytes that were written
  always @(posedge core_clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data <= mem[rd_addr];
      end
    end
  end

endmodule

// ==== design/lpc_cmd_decoder.v ====
`timescale 1ns/10ps
`include "lpc_defs.vh"
// Overview of operation
// R1 - Reserved frame 0x80, 0x90 programs OTP byte
// R2 - OTP broadcast flag zero: program regardless address
// R3 - Move target relative zero, in current resolution
// R4 - Refuse move while any fault flag set
// R5 - Move accepted as dynamic, general, reserved frame
// R6 - Dynamic form: position high byte, low byte
// R7 - General form: command, address, high, low
// R8 - General move broadcast flag zero: all move
// R9 - Master puts LIN parity in identifier top
// R10 - OTP address byte: 11110, index; then data
// R11 - Last three OTP bytes are ignored padding
module lpc_cmd_decoder (
  input  wire        core_clk,              // System clock, 20 MHz
  input  wire        rstn,                  // Asynchronous reset, active low
  input  wire        ce,                    // Clock enable, freezes all state
  input  wire        rx_frame_start,        // Pulse: header received
  input  wire [7:0]  rx_ident,              // Protected identifier with start
  input  wire        rx_byte_valid,         // Pulse: one data byte received
  input  wire [7:0]  rx_byte,               // Data byte with valid
  input  wire        rx_frame_end,          // Pulse: frame complete, checksum good
  input  wire [6:0]  node_address,          // This node's address
  input  wire [4:0]  move_dynamic_id,       // Dynamic id assigned for moves
  input  wire [3:0]  gp_write_id,           // Four-byte general writing id
  input  wire [1:0]  microstep_resolution,  // Current stepping mode
  input  wire        thermal_shutdown_flag, // Fault flag
  input  wire        undervoltage_flag,     // Fault flag
  input  wire        lost_step_flag,        // Fault flag
  input  wire        electrical_fault_flag, // Fault flag
  output reg         otp_program_command,   // Pulse: program one OTP byte
  output reg  [2:0]  otp_byte_index,        // OTP byte to program
  output reg  [7:0]  otp_program_data,      // Data to program
  output reg         absolute_move_command, // Pulse: new target accepted
  output reg  [15:0] target_position,       // Target relative to zero
  output reg  [1:0]  move_resolution,       // Unit of target_position
  output reg         move_refused           // Pulse: move dropped by fault
);

  // ----------------------------------------------------------------
  // States and frame kinds
  // ----------------------------------------------------------------
  localparam S_IDLE  = 3'h0;
  localparam S_FRAME = 3'h1;
  localparam S_READ  = 3'h2;
  localparam S_LAST  = 3'h3;
  localparam S_EVAL  = 3'h4;

  localparam K_NONE = 2'h0;
  localparam K_DYN  = 2'h1;
  localparam K_GP   = 2'h2;
  localparam K_RSV  = 2'h3;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Identifier parity check; the master fills the top bits
  function parity_ok;
    input [7:0] pid;
    begin
      parity_ok = (pid[6] == (pid[0] ^ pid[1] ^ pid[2] ^ pid[4])) &&
                  (pid[7] == ~(pid[1] ^ pid[3] ^ pid[4] ^ pid[5])); // R9
    end
  endfunction

  // Address byte hits this node or is a broadcast
  function addr_hit;
    input [7:0] ab;
    input [6:0] node;
    begin
      addr_hit = ~ab[`LPC_BROAD_BIT] || (ab[6:0] == node); // R2 R8
    end
  endfunction

  reg  [2:0] state;
  reg  [1:0] kind;
  reg  [3:0] count;
  reg  [2:0] rd_idx;
  reg        cap_v;
  reg  [2:0] cap_i;
  reg  [7:0] byt [0:4];
  wire [7:0] rd_data;
  wire       wr_en;
  wire       rd_en;
  wire       fault;
  wire       dyn_go;
  wire       gp_go;
  wire       rsv_base;
  wire       otp_go;
  wire       rsv_move_go;

  assign wr_en = (state == S_FRAME) && rx_byte_valid && (count < `LPC_LEN_MAX);
  assign rd_en = (state == S_READ);
  assign fault = thermal_shutdown_flag | undervoltage_flag | lost_step_flag | electrical_fault_flag;

  // ----------------------------------------------------------------
  // Frame byte store
  // ----------------------------------------------------------------
  lpc_frame_mem #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_mem (
    .core_clk (core_clk),
    .ce       (ce),
    .wr_en    (wr_en),
    .wr_addr  (count[2:0]),
    .wr_data  (rx_byte),
    .rd_en    (rd_en),
    .rd_addr  (rd_idx),
    .rd_data  (rd_data)
  );

  // ----------------------------------------------------------------
  // Frame decode terms
  // ----------------------------------------------------------------
  // Dynamic form needs two bytes: high then low
  assign dyn_go = (kind == K_DYN) && (count >= `LPC_LEN_DYN); // R5 R6
  // General form: command, address, high, low
  assign gp_go = (kind == K_GP) && (count >= `LPC_LEN_GP) &&
                 (byt[0] == `LPC_CMD_MOVE) && addr_hit(byt[1], node_address); // R7
  // Reserved frames must be full length; pad bytes are not examined
  assign rsv_base = (kind == K_RSV) && (count >= `LPC_LEN_RSV) && (byt[0] == `LPC_APP_CMD); // R11
  assign otp_go = rsv_base && (byt[1] == `LPC_CMD_OTP) && addr_hit(byt[2], node_address) &&
                  (byt[3][7:`LPC_OTP_TAG_LSB] == `LPC_OTP_ADDR_TAG); // R1 R10
  // Reserved move serves the first address slot only, no broadcast
  assign rsv_move_go = rsv_base && (byt[1] == `LPC_CMD_MOVE) && (byt[2][6:0] == node_address); // R5

  // ----------------------------------------------------------------
  // Sequencer: collect, read back, evaluate
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state  <= S_IDLE;
      kind   <= K_NONE;
      count  <= 4'h0;
      rd_idx <= 3'h0;
    end else if (ce) begin
      case (state)
        S_IDLE: begin
          if (rx_frame_start) begin
            state <= S_FRAME;
            count <= 4'h0;
            if (!parity_ok(rx_ident)) begin
              kind <= K_NONE; // Corrupt header: swallow the frame
            end else if (rx_ident == `LPC_RESERVED_ID) begin
              kind <= K_RSV;
            end else if (rx_ident[5:0] == {1'b0, move_dynamic_id}) begin
              kind <= K_DYN;
            end else if (rx_ident[5:0] == {`LPC_GP_ID_TAG, gp_write_id}) begin
              kind <= K_GP;
            end else begin
              kind <= K_NONE;
            end
          end
        end
        S_FRAME: begin
          if (rx_frame_start) begin
            count <= 4'h0; // Header without end: previous frame abandoned
            state <= S_IDLE;
          end else if (rx_frame_end) begin
            state  <= (kind == K_NONE) ? S_IDLE : S_READ;
            rd_idx <= 3'h0;
          end else if (wr_en) begin
            count <= count + 4'h1;
          end
        end
        S_READ: begin
          if (rd_idx == `LPC_READ_LAST) begin
            state <= S_LAST;
          end else begin
            rd_idx <= rd_idx + 3'h1;
          end
        end
        S_LAST: begin
          state <= S_EVAL;
        end
        S_EVAL: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Read data arrive one cycle after the request
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cap_v <= 1'b0;
      cap_i <= 3'h0;
    end else if (ce) begin
      cap_v <= rd_en;
      cap_i <= rd_idx;
    end
  end

  // Captured frame bytes 0..4, no reset needed
  always @(posedge core_clk) begin
    if (ce && cap_v) begin
      byt[cap_i] <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Command outputs
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      otp_program_command   <= 1'b0;
      otp_byte_index        <= 3'h0;
      otp_program_data      <= 8'h00;
      absolute_move_command <= 1'b0;
      target_position       <= 16'h0000;
      move_resolution       <= 2'h0;
      move_refused          <= 1'b0;
    end else if (ce) begin
      otp_program_command   <= 1'b0;
      absolute_move_command <= 1'b0;
      move_refused          <= 1'b0;
      if (state == S_EVAL) begin
        if (otp_go) begin
          otp_program_command <= 1'b1; // R1 R2
          otp_byte_index      <= byt[3][2:0]; // R10
          otp_program_data    <= byt[4];
        end
        if (dyn_go || gp_go || rsv_move_go) begin
          if (fault) begin
            move_refused <= 1'b1; // R4
          end else begin
            absolute_move_command <= 1'b1; // R3 R8
            move_resolution       <= microstep_resolution; // R3
            if (dyn_go) begin
              target_position <= {byt[0], byt[1]}; // R6
            end else if (gp_go) begin
              target_position <= {byt[2], byt[3]}; // R7
            end else begin
              target_position <= {byt[3], byt[4]};
            end
          end
        end
      end
    end
  end

endmodule

// ==== verification/lpc_cmd_checker.sv ====
`timescale 1ns/10ps
// ----------------
// Decoder checker
// ----------------
module lpc_cmd_checker (
  input wire        core_clk,              // Clock
  input wire        rstn,                  // Reset
  input wire        rx_frame_end,          // Frame done
  input wire        thermal_shutdown_flag, // Fault
  input wire        undervoltage_flag,     // Fault
  input wire        lost_step_flag,        // Fault
  input wire        electrical_fault_flag, // Fault
  input wire        otp_program_command,   // OTP pulse
  input wire        absolute_move_command, // Move pulse
  input wire [15:0] target_position,       // Target
  input wire        move_refused           // Refusal
);
  // Any fault; the bench holds flags steady across a frame
  wire flt;
  assign flt = thermal_shutdown_flag | undervoltage_flag | lost_step_flag | electrical_fault_flag;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Fixed latency only holds while ce stays high
  a_otp_latency: assert property (otp_program_command |-> $past(rx_frame_end, 8))
    else $error("otp pulse off time");
  a_move_latency: assert property (absolute_move_command |-> $past(rx_frame_end, 8))
    else $error("move pulse off time");
  a_fault_blocks: assert property (absolute_move_command |-> !$past(flt))
    else $error("move taken under fault");
  a_refuse_cause: assert property (move_refused |-> $past(flt) && $past(rx_frame_end, 8))
    else $error("refusal without fault");
  a_one_outcome: assert property (!(absolute_move_command && move_refused))
    else $error("move and refusal together");
  a_move_single: assert property (absolute_move_command |=> !absolute_move_command)
    else $error("move pulse too long");
  a_otp_single: assert property (otp_program_command |=> !otp_program_command)
    else $error("otp pulse too long");
  a_target_hold: assert property (!absolute_move_command |-> $stable(target_position))
    else $error("target moved without command");
endmodule

bind lpc_cmd_decoder lpc_cmd_checker u_chk (.core_clk(core_clk), .rstn(rstn), .rx_frame_end(rx_frame_end),
  .thermal_shutdown_flag(thermal_shutdown_flag), .undervoltage_flag(undervoltage_flag),
  .lost_step_flag(lost_step_flag), .electrical_fault_flag(electrical_fault_flag),
  .otp_program_command(otp_program_command), .absolute_move_command(absolute_move_command),
  .target_position(target_position), .move_refused(move_refused));

// ==== verification/lpc_lin_master.sv ====
`timescale 1ns/10ps
// ------------------
// Frame link master
// ------------------
module lpc_lin_master (
  input  wire       core_clk,              // Clock
  output reg        rx_frame_start = 1'b0, // Header strobe
  output reg  [7:0] rx_ident = 8'h00,      // Protected identifier
  output reg        rx_byte_valid = 1'b0,  // Data strobe
  output reg  [7:0] rx_byte = 8'h00,       // Data byte
  output reg        rx_frame_end = 1'b0    // Frame done strobe
);
  integer i;
  // Header, n bytes from the top of b, end; bad spoils one parity bit
  task send(input [5:0] id, input bad, input [63:0] b, input integer n);
    begin
      @(posedge core_clk) #2;
      rx_frame_start = 1'b1;
      rx_ident = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4] ^ bad, id};
      for (i = 0; i < n; i = i + 1) begin
        @(posedge core_clk) #2;
        rx_frame_start = 1'b0;
        rx_ident = ~rx_ident;
        rx_byte_valid = 1'b1;
        rx_byte = b[63 - 8 * i -: 8];
      end
      @(posedge core_clk) #2;
      rx_byte_valid = 1'b0;
      // Stale byte inverted so it cannot pass for data
      rx_byte = ~rx_byte;
      rx_frame_end = 1'b1;
      @(posedge core_clk) #2;
      rx_frame_end = 1'b0;
      // Gap longer than the eight-cycle evaluation
      repeat (10) @(posedge core_clk);
      #2;
    end
  endtask
endmodule

// ==== verification/tb_lpc_cmd_decoder.sv ====
`timescale 1ns/10ps
// ----------------------------
// Command decoder testbench
// ----------------------------
module tb_lpc_cmd_decoder;
  reg         core_clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [1:0]  mode = 2'h1;
  reg  [3:0]  flt = 4'h0;
  reg  [15:0] fails = 16'h0;
  reg  [15:0] checked = 16'h0;
  reg  [15:0] n_mv = 16'h0;
  reg  [15:0] n_otp = 16'h0;
  reg  [15:0] n_rf = 16'h0;
  wire        fs, bv, fe, otp, mv, rf;
  wire [7:0]  pid, byt, dat;
  wire [2:0]  idx;
  wire [15:0] pos;
  wire [1:0]  res;
  integer     i;
  lpc_lin_master m (.core_clk(core_clk), .rx_frame_start(fs), .rx_ident(pid), .rx_byte_valid(bv),
    .rx_byte(byt), .rx_frame_end(fe));
  lpc_cmd_decoder dut (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .rx_frame_start(fs), .rx_ident(pid),
    .rx_byte_valid(bv), .rx_byte(byt), .rx_frame_end(fe), .node_address(7'h25), .move_dynamic_id(5'h0b),
    .gp_write_id(4'h6), .microstep_resolution(mode), .thermal_shutdown_flag(flt[0]),
    .undervoltage_flag(flt[1]), .lost_step_flag(flt[2]), .electrical_fault_flag(flt[3]),
    .otp_program_command(otp), .otp_byte_index(idx), .otp_program_data(dat), .absolute_move_command(mv),
    .target_position(pos), .move_resolution(res), .move_refused(rf));
  always #25 core_clk = ~core_clk;
  // Pulse tally; exact timing is left to the checker
  always @(posedge core_clk) begin
    if (mv === 1'b1) n_mv <= n_mv + 16'h1;
    if (otp === 1'b1) n_otp <= n_otp + 16'h1;
    if (rf === 1'b1) n_rf <= n_rf + 16'h1;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 16'h1;
      if (got !== exp) begin
        fails = fails + 16'h1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One frame, then the pulses it should leave: exp = {refused, otp, move}
  task run(input [5:0] id, input bad, input [63:0] b, input integer n, input [2:0] exp);
    reg [15:0] m0, o0, r0;
    begin
      m0 = n_mv;
      o0 = n_otp;
      r0 = n_rf;
      m.send(id, bad, b, n);
      chk(n_mv - m0, {15'h0, exp[0]});
      chk(n_otp - o0, {15'h0, exp[1]});
      chk(n_rf - r0, {15'h0, exp[2]});
    end
  endtask
  task test_done;
    begin
      $display("checked %0d, failed %0d", checked, fails);
      if (fails == 16'h0 && checked != 16'h0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // Watchdog: about 300 cycles of frames expected, 4000 allowed
  initial begin
    #200000;
    fails = fails + 16'h1;
    test_done;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #2;
    rstn = 1'b1;
    run(6'h0b, 1'b0, 64'h1234_0000_0000_0000, 2, 3'b001);
    chk(pos, 16'h1234);
    chk({14'h0, res}, 16'h0001);
    mode = 2'h2;
    run(6'h26, 1'b0, 64'h8b25_abcd_0000_0000, 4, 3'b001);
    chk({14'h0, res}, 16'h0002);
    run(6'h26, 1'b0, 64'h8b13_5678_0000_0000, 4, 3'b001);
    run(6'h26, 1'b0, 64'h8b93_1111_0000_0000, 4, 3'b000);
    chk(pos, 16'h5678);
    run(6'h3c, 1'b0, 64'h808b_259a_bcff_ffff, 8, 3'b001);
    chk(pos, 16'h9abc);
    run(6'h0b, 1'b1, 64'h4321_0000_0000_0000, 2, 3'b000);
    $display("test moves done");
    run(6'h3c, 1'b0, 64'h8090_a5f5_aaff_ffff, 8, 3'b010);
    chk({5'h0, idx, dat}, 16'h05aa);
    run(6'h3c, 1'b0, 64'h8090_13f2_5cff_ffff, 8, 3'b010);
    chk({5'h0, idx, dat}, 16'h025c);
    run(6'h3c, 1'b0, 64'h8090_a5e5_77ff_ffff, 8, 3'b000);
    run(6'h3c, 1'b0, 64'h8090_a5f4_3300_0000, 8, 3'b010);
    chk({5'h0, idx, dat}, 16'h0433);
    $display("test otp done");
    for (i = 0; i < 4; i = i + 1) begin
      flt = 4'h1 << i;
      run(6'h26, 1'b0, 64'h8b25_1111_0000_0000, 4, 3'b100);
      chk(pos, 16'h9abc);
    end
    $display("test faults done");
    test_done;
  end
endmodule
